// ==== pkg/sgc_pkg.sv ====
// Function
// - Reserve bit and multi-queue on: 48 buffers per port for queues 3 to 1.
// - Reserve off or single queue: 48 buffers per port shared by all queues.
// - Bit 7 of 0x05 turns 802.1Q VLAN forwarding on; resets to zero.
// - Bit 6 of 0x05 enables IGMP snooping; IGMP packets go to the MII port.
// - Bits 5 and 4 of 0x05 enable MLD snooping and its option; reset zero.
// - Fair queue bit clear: strict priority, higher queue always sent first.
// - Weighted fair queuing with all queues busy shares bandwidth 8:4:2:1.
// - Empty queues weigh zero; highest non-empty queue gains one more unit.
// - Sniff mode one: mirror only if source and destination both match.
// - Sniff mode zero (default): mirror if source or destination matches.
// - Bit 6 of 0x06 sets MII half duplex; default from pulled-down strap.
// - Bit 5 of 0x06 enables MII flow control; default from a strap pin.
package sgc_pkg;

  // Register offsets on the management port.
  localparam logic [7:0] SGC_ADDR_BUF = 8'h04;
  localparam logic [7:0] SGC_ADDR_FWD = 8'h05;
  localparam logic [7:0] SGC_ADDR_MODE = 8'h06;

  // Field positions.
  localparam int SGC_BIT_PBR = 0;
  localparam int SGC_BIT_VLAN = 7;
  localparam int SGC_BIT_IGMP = 6;
  localparam int SGC_BIT_MLD = 5;
  localparam int SGC_BIT_MLD_OPT = 4;
  localparam int SGC_BIT_WFQ = 3;
  localparam int SGC_BIT_SNIFF = 0;
  localparam int SGC_BIT_REPEAT = 7;
  localparam int SGC_BIT_HDX = 6;
  localparam int SGC_BIT_FC = 5;

  // Reset values; the strap fields are overwritten just after release.
  localparam logic [7:0] SGC_BUF_RST = 8'h01;
  localparam logic [7:0] SGC_FWD_RST = 8'h00;
  localparam logic [7:0] SGC_MODE_RST = 8'h00;
  localparam logic [7:0] SGC_BUF_MASK = 8'h01;
  localparam logic [7:0] SGC_MODE_MASK = 8'he0;
  localparam logic [7:0] SGC_UNMAPPED = 8'h00;

  // Buffer allocation and scheduler weights.
  localparam logic [5:0] SGC_BUF_PER_PORT = 6'h30;
  localparam int SGC_NUM_Q = 4;
  localparam logic [15:0] SGC_WEIGHTS = 16'h8421;
  localparam logic [3:0] SGC_W_BONUS = 4'h1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } sgc_reg_req_type;

  typedef struct packed {
    logic vlan_en;
    logic igmp_snoop;
    logic mld_snoop;
    logic mld_option;
    logic wfq_en;
    logic sniff_and;
    logic repeater;
    logic mii_half_duplex;
    logic mii_flow_ctl;
  } sgc_cfg_type;

endpackage

// ==== verilog/sgc_wfq_arb.sv ====
`timescale 1ns/10ps
`default_nettype none
module sgc_wfq_arb
  import sgc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Scheduling control.
  input wire logic wfq_en,
  input wire logic [3:0] queue_nonempty,
  input wire logic tx_slot,
  // Grant.
  output logic [3:0] grant,
  output logic grant_valid
);

  logic [3:0] credit [SGC_NUM_Q];
  logic [3:0] next_credit [SGC_NUM_Q];
  logic [3:0] next_grant;
  logic next_grant_valid;

  // Index of the highest set bit; queue 3 is the top priority queue.
  function automatic logic [1:0] top_of(input logic [3:0] v);
    top_of = 2'h0;
    for (int i = 0; i < SGC_NUM_Q; i++)
    begin
      if (v[i]) top_of = 2'(i);
    end
  endfunction

  // Weight of one queue for a new round, given which queues are busy.
  function automatic logic [3:0] weight_of(input logic [3:0] ne,
                                           input int q);
    weight_of = ne[q] ? SGC_WEIGHTS[q*4 +: 4] : 4'h0;
    if (ne != 4'hf && ne[q] && top_of(ne) == 2'(q))
      weight_of = weight_of + SGC_W_BONUS;
  endfunction

  // A round serves the top queue first until its credit runs out, so each
  // round yields the weight ratio; a new round starts when no busy queue has credit left.
  always_comb
  begin
    logic [3:0] elig;
    logic [1:0] pick;
    elig = 4'h0;
    pick = 2'h0;
    next_credit = credit;
    next_grant = 4'h0;
    next_grant_valid = 1'b0;
    for (int i = 0; i < SGC_NUM_Q; i++)
      elig[i] = queue_nonempty[i] && credit[i] != 4'h0;
    if (tx_slot && queue_nonempty != 4'h0)
    begin
      next_grant_valid = 1'b1;
      if (!wfq_en)
      begin
        pick = top_of(queue_nonempty);
      end
      else if (elig == 4'h0)
      begin
        for (int i = 0; i < SGC_NUM_Q; i++)
          next_credit[i] = weight_of(queue_nonempty, i);
        pick = top_of(queue_nonempty);
        next_credit[pick] = next_credit[pick] - 4'h1;
      end
      else
      begin
        pick = top_of(elig);
        next_credit[pick] = credit[pick] - 4'h1;
      end
      next_grant[pick] = 1'b1;
    end
  end

  // Registered grant and credits.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SGC_NUM_Q; i++)
        credit[i] <= 4'h0;
      grant <= 4'h0;
      grant_valid <= 1'b0;
    end
    else
    begin
      credit <= next_credit;
      grant <= next_grant;
      grant_valid <= next_grant_valid;
    end
  end

  chk_strict_top_grant: assert property
    (@(posedge core_clk) disable iff (rst)
    tx_slot && !wfq_en && queue_nonempty != 4'h0 |=>
    grant == (4'h1 << top_of($past(queue_nonempty))))
    else $error("strict priority did not grant the highest busy queue");

  chk_wfq_full_round: assert property
    (@(posedge core_clk) disable iff (rst)
    wfq_en && tx_slot && queue_nonempty == 4'hf && credit[0] == 4'h0 &&
    credit[1] == 4'h0 && credit[2] == 4'h0 && credit[3] == 4'h0 |=>
    grant[3] && credit[3] == 4'h7 && credit[2] == 4'h4 &&
    credit[1] == 4'h2 && credit[0] == 4'h1)
    else $error("full round did not load weights 8:4:2:1");

  chk_wfq_bonus_weight: assert property
    (@(posedge core_clk) disable iff (rst)
    wfq_en && tx_slot && queue_nonempty == 4'hb && credit[0] == 4'h0 &&
    credit[1] == 4'h0 && credit[3] == 4'h0 |=>
    credit[3] == 4'h8 && credit[2] == 4'h0 && credit[1] == 4'h2)
    else $error("empty queue round did not give 9:0:2:1");

endmodule // sgc_wfq_arb
`default_nettype wire

// ==== verilog/sgc_global_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module sgc_global_ctrl
  import sgc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Management register port.
  input wire sgc_reg_req_type reg_req,
  output logic [7:0] reg_rd_data,
  // Strap pins, sampled around reset.
  input wire logic duplex_strap_pin,
  input wire logic flow_ctl_strap_pin,
  // Queue manager.
  input wire logic multi_queue_en,
  output logic buf_hi_reserved,
  output logic [5:0] buf_quota,
  input wire logic [3:0] queue_nonempty,
  input wire logic tx_slot,
  output logic [3:0] queue_grant,
  output logic queue_grant_valid,
  // Mirroring.
  input wire logic pkt_valid,
  input wire logic src_port_match,
  input wire logic dst_port_match,
  output logic mirror_pkt,
  // Forwarding configuration.
  output sgc_cfg_type cfg
);

  logic [7:0] buf_reg;
  logic [7:0] fwd_reg;
  logic [7:0] mode_reg;
  logic [7:0] next_buf_reg;
  logic [7:0] next_fwd_reg;
  logic [7:0] next_mode_reg;
  logic [7:0] next_rd_data;
  logic strap_done;
  logic dup_meta;
  logic dup_sync;
  logic fc_meta;
  logic fc_sync;
  logic next_hi_reserved;
  logic next_mirror;

  // Strap synchronisers carry no reset so they keep sampling the pins
  // while reset is held; their result is taken on the first edge after.
  always_ff @(posedge core_clk)
  begin
    dup_meta <= duplex_strap_pin;
    dup_sync <= dup_meta;
    fc_meta <= flow_ctl_strap_pin;
    fc_sync <= fc_meta;
  end

  // Register writes and the one-time strap load.
  always_comb
  begin
    next_buf_reg = buf_reg;
    next_fwd_reg = fwd_reg;
    next_mode_reg = mode_reg;
    if (!strap_done)
    begin
      next_mode_reg[SGC_BIT_HDX] = dup_sync;
      next_mode_reg[SGC_BIT_FC] = fc_sync;
    end
    else if (reg_req.wr)
    begin
      // Written values stay until the next write or reset.
      unique case (reg_req.addr)
        SGC_ADDR_BUF: next_buf_reg = reg_req.data & SGC_BUF_MASK;
        SGC_ADDR_FWD: next_fwd_reg = reg_req.data;
        SGC_ADDR_MODE: next_mode_reg = reg_req.data & SGC_MODE_MASK;
        default: next_buf_reg = buf_reg;
      endcase
    end
  end

  // Read data; unmapped addresses and absent bits of 0x04 and 0x06 read as zero.
  always_comb
  begin
    next_rd_data = reg_rd_data;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        SGC_ADDR_BUF: next_rd_data = buf_reg;
        SGC_ADDR_FWD: next_rd_data = fwd_reg;
        SGC_ADDR_MODE: next_rd_data = mode_reg;
        default: next_rd_data = SGC_UNMAPPED;
      endcase
    end
  end

  // Register file state.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      buf_reg <= SGC_BUF_RST;
      fwd_reg <= SGC_FWD_RST;
      mode_reg <= SGC_MODE_RST;
      strap_done <= 1'b0;
      reg_rd_data <= SGC_UNMAPPED;
    end
    else
    begin
      buf_reg <= next_buf_reg;
      fwd_reg <= next_fwd_reg;
      mode_reg <= next_mode_reg;
      strap_done <= 1'b1;
      reg_rd_data <= next_rd_data;
    end
  end

  // Configuration fans out straight from the register bits.
  assign cfg.vlan_en = fwd_reg[SGC_BIT_VLAN];
  assign cfg.igmp_snoop = fwd_reg[SGC_BIT_IGMP];
  assign cfg.mld_snoop = fwd_reg[SGC_BIT_MLD];
  assign cfg.mld_option = fwd_reg[SGC_BIT_MLD_OPT];
  assign cfg.wfq_en = fwd_reg[SGC_BIT_WFQ];
  assign cfg.sniff_and = fwd_reg[SGC_BIT_SNIFF];
  assign cfg.repeater = mode_reg[SGC_BIT_REPEAT];
  assign cfg.mii_half_duplex = mode_reg[SGC_BIT_HDX];
  assign cfg.mii_flow_ctl = mode_reg[SGC_BIT_FC];

  // Reservation only means something with several queues; the per-port
  // count is the same either way, only its users change.
  always_comb
  begin
    next_hi_reserved = buf_reg[SGC_BIT_PBR] && multi_queue_en;
    next_mirror = 1'b0;
    if (pkt_valid)
    begin
      if (fwd_reg[SGC_BIT_SNIFF])
        next_mirror = src_port_match && dst_port_match;
      else
        next_mirror = src_port_match || dst_port_match;
    end
  end

  // Registered queue and mirror decisions.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      buf_hi_reserved <= 1'b0;
      mirror_pkt <= 1'b0;
    end
    else
    begin
      buf_hi_reserved <= next_hi_reserved;
      mirror_pkt <= next_mirror;
    end
  end

  assign buf_quota = SGC_BUF_PER_PORT;

  // Egress scheduler.
  sgc_wfq_arb u_arb (
    .core_clk(core_clk),
    .rst(rst),
    .wfq_en(fwd_reg[SGC_BIT_WFQ]),
    .queue_nonempty(queue_nonempty),
    .tx_slot(tx_slot),
    .grant(queue_grant),
    .grant_valid(queue_grant_valid)
  );

  sequence s_fwd_write;
    strap_done && reg_req.wr && reg_req.addr == SGC_ADDR_FWD;
  endsequence

  chk_reserve_needs_mq: assert property
    (@(posedge core_clk) disable iff (rst)
    buf_hi_reserved |-> $past(buf_reg[SGC_BIT_PBR] && multi_queue_en))
    else $error("high priority reserve without bit and multi-queue");

  chk_shared_when_off: assert property
    (@(posedge core_clk) disable iff (rst)
    !multi_queue_en |=> !buf_hi_reserved && buf_quota == 6'h30)
    else $error("buffers not shared while multi-queue is off");

  chk_vlan_follows_wr: assert property
    (@(posedge core_clk) disable iff (rst)
    s_fwd_write |=> cfg.vlan_en == $past(reg_req.data[SGC_BIT_VLAN]))
    else $error("VLAN enable did not take written value");

  chk_snoop_bits_wr: assert property
    (@(posedge core_clk) disable iff (rst)
    s_fwd_write |=> cfg.igmp_snoop == $past(reg_req.data[SGC_BIT_IGMP]) &&
    cfg.mld_snoop == $past(reg_req.data[SGC_BIT_MLD]) &&
    cfg.mld_option == $past(reg_req.data[SGC_BIT_MLD_OPT]))
    else $error("snoop enables did not take written values");

  chk_sniff_and_mode: assert property
    (@(posedge core_clk) disable iff (rst)
    pkt_valid && cfg.sniff_and |=>
    mirror_pkt == $past(src_port_match && dst_port_match))
    else $error("AND sniff mirrored wrongly");

  chk_sniff_or_mode: assert property
    (@(posedge core_clk) disable iff (rst)
    pkt_valid && !cfg.sniff_and |=>
    mirror_pkt == $past(src_port_match || dst_port_match))
    else $error("OR sniff mirrored wrongly");

  chk_strap_first_edge: assert property
    (@(posedge core_clk) disable iff (rst)
    !strap_done |=> cfg.mii_half_duplex == $past(dup_sync) &&
    cfg.mii_flow_ctl == $past(fc_sync))
    else $error("strap defaults not loaded after reset");

  chk_fields_hold: assert property
    (@(posedge core_clk) disable iff (rst)
    strap_done && !reg_req.wr |=> $stable(fwd_reg) && $stable(mode_reg) &&
    $stable(buf_reg))
    else $error("register changed without a write");

endmodule // sgc_global_ctrl
`default_nettype wire

// ==== verif/test_switch_global_control_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_switch_global_control_regs;
  import sgc_pkg::*;

  logic core_clk;
  logic rst;
  sgc_reg_req_type reg_req;
  logic [7:0] reg_rd_data;
  logic duplex_strap_pin;
  logic flow_ctl_strap_pin;
  logic multi_queue_en;
  logic buf_hi_reserved;
  logic [5:0] buf_quota;
  logic [3:0] queue_nonempty;
  logic tx_slot;
  logic [3:0] queue_grant;
  logic queue_grant_valid;
  logic pkt_valid;
  logic src_port_match;
  logic dst_port_match;
  logic mirror_pkt;
  sgc_cfg_type cfg;
  int fails;
  int tests_run;
  logic [7:0] d;
  logic [7:0] g;
  int cnt [4];

  sgc_global_ctrl dut (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rd_data(reg_rd_data), .duplex_strap_pin(duplex_strap_pin),
    .flow_ctl_strap_pin(flow_ctl_strap_pin), .multi_queue_en(multi_queue_en),
    .buf_hi_reserved(buf_hi_reserved), .buf_quota(buf_quota),
    .queue_nonempty(queue_nonempty), .tx_slot(tx_slot),
    .queue_grant(queue_grant), .queue_grant_valid(queue_grant_valid),
    .pkt_valid(pkt_valid), .src_port_match(src_port_match),
    .dst_port_match(dst_port_match), .mirror_pkt(mirror_pkt), .cfg(cfg));

  // Free-running 50 MHz clock.
  always #10 core_clk = ~core_clk;

  // One comparison; case inequality so an unknown never matches.
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Straps are drawn at random and held through reset and after release.
  task automatic do_reset();
    rst = 1'b1;
    duplex_strap_pin = 1'($urandom);
    flow_ctl_strap_pin = 1'($urandom);
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // A request stands for exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
    @(negedge core_clk);
    reg_req = '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(negedge core_clk);
    reg_req = '0;
    chk("reg_rd_data", exp, reg_rd_data);
  endtask

  // One egress slot; the grant has landed by the following falling edge.
  task automatic slot(input logic [3:0] ne);
    @(negedge core_clk);
    queue_nonempty = ne;
    tx_slot = 1'b1;
    @(negedge core_clk);
    tx_slot = 1'b0;
  endtask

  function automatic logic [3:0] top_of(input logic [3:0] ne);
    for (int q = 3; q >= 0; q--)
      if (ne[q])
        return 4'(1 << q);
    return 4'h0;
  endfunction

  // Weight per queue: nominal for busy queues, one bonus for the top busy queue when any is empty.
  function automatic logic [7:0] weight(input logic [3:0] ne, input int q);
    logic [7:0] w;
    w = ne[q] ? 8'(SGC_WEIGHTS[4*q +: 4]) : 8'h00;
    if (ne != 4'hf && top_of(ne) == 4'(1 << q))
      w = w + 8'(SGC_W_BONUS);
    return w;
  endfunction

  // Counts grants per queue over whole rounds, checking one-hot grants.
  task automatic wfq_round(input logic [3:0] ne, input int n);
    cnt = '{0, 0, 0, 0};
    repeat (n)
    begin
      slot(ne);
      chk("queue_grant_valid", 8'h01, 8'(queue_grant_valid));
      chk("grant_onehot", 8'h01, 8'($countones(queue_grant)));
      for (int q = 0; q < 4; q++)
        cnt[q] += int'(queue_grant[q]);
    end
    for (int q = 0; q < 4; q++)
      chk("wfq_share", weight(ne, q), 8'(cnt[q]));
  endtask

  // Main sequence; every design input is given a value at time zero.
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    reg_req = '0;
    multi_queue_en = 1'b0;
    queue_nonempty = 4'h0;
    tx_slot = 1'b0;
    pkt_valid = 1'b0;
    src_port_match = 1'b0;
    dst_port_match = 1'b0;
    fails = 0;
    tests_run = 0;
    void'($urandom(32'h6c1d_52ec));
    do_reset();
    rd_chk(SGC_ADDR_BUF, SGC_BUF_RST);
    rd_chk(SGC_ADDR_FWD, SGC_FWD_RST);
    // Repeater is bit 7, so the straps land on bits 6 and 5.
    d = {1'b0, duplex_strap_pin, flow_ctl_strap_pin, 5'h00};
    rd_chk(SGC_ADDR_MODE, d);
    chk("buf_quota", 8'h30, 8'(buf_quota));
    // Random writes; the reserved pair is left at its default by software.
    repeat (6)
    begin
      d = 8'($urandom) & 8'hf9;
      // No VLAN table lives in this slice, so the enable may be set at once.
      wr(SGC_ADDR_FWD, d);
      rd_chk(SGC_ADDR_FWD, d);
      g = 8'({cfg.vlan_en, cfg.igmp_snoop, cfg.mld_snoop, cfg.mld_option,
        cfg.wfq_en, cfg.sniff_and});
      chk("cfg_fwd", 8'({d[7:3], d[0]}), g);
      d = 8'($urandom);
      wr(SGC_ADDR_MODE, d);
      rd_chk(SGC_ADDR_MODE, d & 8'he0);
      g = 8'({cfg.repeater, cfg.mii_half_duplex, cfg.mii_flow_ctl});
      chk("cfg_mode", 8'(d[7:5]), g);
      wr(8'h07, d);
      rd_chk(8'h07, SGC_UNMAPPED);
    end
    // Reserve bit against multi-queue operation, all four pairings.
    for (int i = 0; i < 4; i++)
    begin
      wr(SGC_ADDR_BUF, {7'h00, i[1]});
      rd_chk(SGC_ADDR_BUF, {7'h00, i[1]});
      multi_queue_en = i[0];
      @(negedge core_clk);
      chk("buf_hi_reserved", 8'(i[1] & i[0]), 8'(buf_hi_reserved));
    end
    // Mirror decision in both sniff modes over every match combination.
    for (int m = 0; m < 2; m++)
    begin
      wr(SGC_ADDR_FWD, {7'h00, m[0]});
      for (int i = 0; i < 8; i++)
      begin
        @(negedge core_clk);
        {pkt_valid, src_port_match, dst_port_match} = i[2:0];
        @(negedge core_clk);
        pkt_valid = 1'b0;
        d = 8'(i[2] & (m[0] ? i[1] & i[0] : i[1] | i[0]));
        chk("mirror_pkt", d, 8'(mirror_pkt));
      end
    end
    // Strict priority with random occupancy; the first slot finds all empty.
    wr(SGC_ADDR_FWD, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      slot(i == 0 ? 4'h0 : 4'($urandom));
      d = 8'(queue_nonempty != 4'h0);
      chk("queue_grant_valid", d, 8'(queue_grant_valid));
      chk("queue_grant", 8'(top_of(queue_nonempty)), 8'(queue_grant));
    end
    // A second reset starts a fresh scheduling round for the weighted tests.
    do_reset();
    d = {1'b0, duplex_strap_pin, flow_ctl_strap_pin, 5'h00};
    rd_chk(SGC_ADDR_MODE, d);
    wr(SGC_ADDR_FWD, 8'h08);
    wfq_round(4'hf, 15);
    wfq_round(4'hb, 12);
    summarize();
  end

  // Watchdog: the sequence needs well under 2,000 cycles.
  initial
  begin
    #200000;
    fails++;
    summarize();
  end
endmodule // test_switch_global_control_regs
`default_nettype wire
